/* File: synth_host.sv */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module synth_host
  import synth_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  serial_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum {IDLE, LOW, HIGH, LOAD, DONE} st_t;
  st_t st_ff;
  logic [WORD_W-1:0] data_ff, word_ff;
  logic [4:0] bit_ff;
  logic [7:0] div_ff;
  logic aw_ff, w_ff, bv_ff, rv_ff, sclk_ff, sdat_ff, le_ff;
  logic [3:0] awa_ff;
  logic [31:0] wd_ff, rd_ff;
  logic [1:0] br_ff, rr_ff;
  wire tick = (div_ff == SCLK_DIV);
  wire busy = (st_ff != IDLE);
  wire do_wr = aw_ff && w_ff && !bv_ff;
  wire wr_data = do_wr && (awa_ff == ADDR_DATA);
  wire wr_ctrl = do_wr && (awa_ff == ADDR_CTRL);
  wire wr_ok = wr_data || (wr_ctrl && !busy);
  wire go = wr_ctrl && !busy && wd_ff[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OKAY;
      rv_ff <= 1'b0;
      rd_ff <= '0;
      rr_ff <= RESP_OKAY;
      data_ff <= '0;
    end else begin
      if (s_axi_awvalid && !aw_ff) begin
        aw_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ff) begin
        w_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_data) data_ff <= WORD_W'(wd_ff);
      end
      if (bv_ff && s_axi_bready) bv_ff <= 1'b0;
      if (s_axi_arvalid && !rv_ff) begin
        rv_ff <= 1'b1;
        rr_ff <= (s_axi_araddr == ADDR_DATA || s_axi_araddr == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
        rd_ff <= (s_axi_araddr == ADDR_DATA) ? 32'(data_ff) : (s_axi_araddr == ADDR_STAT) ? 32'(busy) : '0;
      end
      if (rv_ff && s_axi_rready) rv_ff <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= IDLE;
      word_ff <= '0;
      bit_ff <= '0;
      div_ff <= '0;
      sclk_ff <= 1'b0;
      sdat_ff <= 1'b0;
      le_ff <= 1'b0;
    end else begin
      div_ff <= (tick || !busy) ? '0 : 8'(div_ff + 8'h01);
      unique case (st_ff)
        IDLE: if (go) begin
          word_ff <= data_ff;
          bit_ff <= 5'(WORD_W - 1);
          st_ff <= LOW;
        end
        LOW: if (tick) begin
          sdat_ff <= word_ff[bit_ff];
          sclk_ff <= 1'b0;
          st_ff <= HIGH;
        end
        HIGH: if (tick) begin
          sclk_ff <= 1'b1;
          if (bit_ff == '0) st_ff <= LOAD;
          else begin
            bit_ff <= 5'(bit_ff - 5'h01);
            st_ff <= LOW;
          end
        end
        LOAD: if (tick) begin
          sclk_ff <= 1'b0;
          le_ff <= 1'b1;
          st_ff <= DONE;
        end
        DONE: if (tick) begin
          le_ff <= 1'b0;
          st_ff <= IDLE;
        end
      endcase
    end
  end
  assign link.serial_clock = sclk_ff;
  assign link.serial_data = sdat_ff;
  assign link.load_strobe = le_ff;
  assign s_axi_awready = !aw_ff;
  assign s_axi_wready = !w_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
endmodule

/* File: synth_pkg.sv */
package synth_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_LOW_REF = 2'h0;
  localparam logic [1:0] SEL_LOW_FB = 2'h1;
  localparam logic [1:0] SEL_HIGH_REF = 2'h2;
  localparam logic [1:0] SEL_HIGH_FB = 2'h3;
  // Reference-divider latch fields
  localparam int REF_CP_HI = 23;
  localparam int REF_CP_LO = 21;
  localparam int REF_MUX_HI = 20;
  localparam int REF_MUX_LO = 19;
  localparam int REF_TRI = 18;
  localparam int REF_POL = 17;
  localparam int REF_R_HI = 16;
  localparam int REF_R_LO = 2;
  // Feedback-divider latch fields
  localparam int FB_GAIN = 23;
  localparam int FB_PD = 22;
  localparam int FB_PRE_HI = 21;
  localparam int FB_PRE_LO = 20;
  localparam int FB_B_HI = 19;
  localparam int FB_B_LO = 8;
  localparam int FB_A_HI = 7;
  localparam int FB_A_LO = 2;
  localparam int R_W = 15;
  localparam int B_W = 12;
  localparam int A_W = 6;
  localparam logic [B_W-1:0] B_MIN = 12'h003;
  // Lock detect windows in ns, converted with the 10 ns clock
  localparam int CLK_NS = 10;
  localparam int LOCK_IN_NS = 15;
  localparam int LOCK_OUT_NS = 25;
  localparam logic [7:0] LOCK_IN_CYC = 8'((LOCK_IN_NS - 1) / CLK_NS);
  localparam logic [7:0] LOCK_OUT_CYC = 8'(LOCK_OUT_NS / CLK_NS);
  localparam logic [1:0] LOCK_COUNT = 2'h3;
  // Host register map, byte addresses
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [7:0] SCLK_DIV = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: serial_link_if.sv */
`timescale 1ns/1ns
interface serial_link_if;
  logic serial_clock;
  logic serial_data;
  logic load_strobe;
  modport host (output serial_clock, output serial_data, output load_strobe);
  modport device (input serial_clock, input serial_data, input load_strobe);
endinterface

/* File: loop_section.sv */
`timescale 1ns/1ns
module loop_section
  import synth_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_edge,
  input wire logic vco_edge,
  input wire logic [WORD_W-1:0] ref_latch,
  input wire logic [WORD_W-1:0] fb_latch,
  output logic detector_up,
  output logic detector_down,
  output logic lock_detect,
  output logic ref_div_out,
  output logic fb_div_out,
  output logic speedup_output,
  output logic pump_tristate,
  output logic [2:0] pump_current
);
  logic [R_W-1:0] r_cnt_ff;
  logic [6:0] pre_cnt_ff;
  logic [B_W-1:0] b_cnt_ff;
  logic [A_W-1:0] a_cnt_ff;
  logic ref_pulse_ff, fb_pulse_ff, up_ff, dn_ff, lock_ff;
  logic [7:0] err_ff;
  logic [1:0] good_ff;
  wire powered_down = fb_latch[FB_PD];
  wire [R_W-1:0] r_val = ref_latch[REF_R_HI:REF_R_LO];
  wire [B_W-1:0] b_val = fb_latch[FB_B_HI:FB_B_LO];
  wire [A_W-1:0] a_val = fb_latch[FB_A_HI:FB_A_LO];
  wire [1:0] pre_sel = fb_latch[FB_PRE_HI:FB_PRE_LO];
  wire [6:0] modulus = 7'(7'h08 << pre_sel);
  wire [6:0] pre_top = (a_cnt_ff != '0) ? modulus : 7'(modulus - 7'h01);
  wire pre_wrap = vco_edge && (pre_cnt_ff >= pre_top);
  wire r_wrap = ref_edge && (r_cnt_ff + 15'h0001 >= r_val);
  wire b_wrap = pre_wrap && (b_cnt_ff + 12'h001 >= b_val);
  wire pol = ref_latch[REF_POL];
  always_ff @(posedge aclk) begin
    if (!aresetn || powered_down) begin
      r_cnt_ff <= '0;
      pre_cnt_ff <= '0;
      b_cnt_ff <= '0;
      a_cnt_ff <= '0;
      ref_pulse_ff <= 1'b0;
      fb_pulse_ff <= 1'b0;
    end else begin
      if (ref_edge) r_cnt_ff <= r_wrap ? '0 : 15'(r_cnt_ff + 15'h0001);
      ref_pulse_ff <= r_wrap;
      if (vco_edge) pre_cnt_ff <= pre_wrap ? '0 : 7'(pre_cnt_ff + 7'h01);
      if (pre_wrap) begin
        b_cnt_ff <= b_wrap ? '0 : 12'(b_cnt_ff + 12'h001);
        a_cnt_ff <= b_wrap ? a_val : ((a_cnt_ff != '0) ? 6'(a_cnt_ff - 6'h01) : a_cnt_ff);
      end
      fb_pulse_ff <= b_wrap;
    end
  end
  wire up_set = pol ? ref_pulse_ff : fb_pulse_ff;
  wire dn_set = pol ? fb_pulse_ff : ref_pulse_ff;
  wire both = (up_ff || up_set) && (dn_ff || dn_set);
  wire err_end = both && (up_ff || dn_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn || powered_down) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
      err_ff <= '0;
      good_ff <= '0;
      lock_ff <= 1'b0;
    end else begin
      up_ff <= both ? 1'b0 : (up_ff || up_set);
      dn_ff <= both ? 1'b0 : (dn_ff || dn_set);
      if (up_ff ^ dn_ff) err_ff <= (err_ff == 8'hFF) ? err_ff : 8'(err_ff + 8'h01);
      if (err_end) begin
        err_ff <= '0;
        if (err_ff <= LOCK_IN_CYC) begin
          good_ff <= (good_ff == LOCK_COUNT) ? good_ff : 2'(good_ff + 2'h1);
          if (good_ff + 2'h1 >= LOCK_COUNT) lock_ff <= 1'b1;
        end else good_ff <= '0;
        if (err_ff > LOCK_OUT_CYC) lock_ff <= 1'b0;
      end
    end
  end
  assign pump_tristate = ref_latch[REF_TRI] || powered_down;
  assign speedup_output = fb_latch[FB_GAIN];
  assign pump_current = fb_latch[FB_GAIN] ? 3'h7 : ref_latch[REF_CP_HI:REF_CP_LO];
  assign detector_up = up_ff && !pump_tristate;
  assign detector_down = dn_ff && !pump_tristate;
  assign lock_detect = lock_ff;
  assign ref_div_out = ref_pulse_ff;
  assign fb_div_out = fb_pulse_ff;
endmodule

/* File: synth_device.sv */
`timescale 1ns/1ns
// Functional notes
// - shift one bit per serial rise
// - host sends MSB first
// - load rise copies to one latch
// - bits 1..0 pick the latch
// - 00,01,10,11 map to four latches
// - four mux bits drive test output
// - prescaler 8/9 up to 64/65
// - ratio is P times B plus A
// - main counter 12 bits, 3..4095
// - swallow counter 6 bits, 0..63
// - 15-bit reference divider ratio
// - host keeps prescaler under 188 MHz
// - lock after three good cycles
// - lock drops above 25 ns
// - analog lock: high, low pulses
// - each loop has A, B, R
// - prescaler from 4/5 core
// - detector compares R and N
// - two prescaler bits per loop
// - tristate bit floats pump
// - gain bit enables speed-up
// - latches work in power-down
module synth_device
  import synth_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  serial_link_if.device link,
  input wire logic reference_input,
  input wire logic low_band_vco_input,
  input wire logic high_band_vco_input,
  output logic test_mux_output,
  output logic test_mux_output_oe,
  output logic speedup_output,
  output logic [1:0] detector_up,
  output logic [1:0] detector_down,
  output logic [1:0] pump_tristate,
  output logic [5:0] pump_current,
  output logic [WORD_W-1:0] low_band_ref_divider_latch,
  output logic [WORD_W-1:0] low_band_feedback_divider_latch,
  output logic [WORD_W-1:0] high_band_ref_divider_latch,
  output logic [WORD_W-1:0] high_band_feedback_divider_latch
);
  logic [2:0] sclk_sync_ff, sdat_sync_ff, load_sync_ff;
  logic [2:0] ref_sync_ff, lo_sync_ff, hi_sync_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] lat_ff [4];
  logic mux_ff, mux_oe_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_sync_ff <= '0;
      sdat_sync_ff <= '0;
      load_sync_ff <= '0;
      ref_sync_ff <= '0;
      lo_sync_ff <= '0;
      hi_sync_ff <= '0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], link.serial_clock};
      sdat_sync_ff <= {sdat_sync_ff[1:0], link.serial_data};
      load_sync_ff <= {load_sync_ff[1:0], link.load_strobe};
      ref_sync_ff <= {ref_sync_ff[1:0], reference_input};
      lo_sync_ff <= {lo_sync_ff[1:0], low_band_vco_input};
      hi_sync_ff <= {hi_sync_ff[1:0], high_band_vco_input};
    end
  end
  wire sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
  wire load_rise = load_sync_ff[1] && !load_sync_ff[2];
  wire ref_edge = ref_sync_ff[1] && !ref_sync_ff[2];
  wire lo_edge = lo_sync_ff[1] && !lo_sync_ff[2];
  wire hi_edge = hi_sync_ff[1] && !hi_sync_ff[2];
  wire [SEL_W-1:0] sel = shift_ff[SEL_W-1:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_ff <= '0;
      for (int i = 0; i < 4; i++) lat_ff[i] <= '0;
    end else begin
      if (sclk_rise) shift_ff <= {shift_ff[WORD_W-2:0], sdat_sync_ff[1]};
      if (load_rise) lat_ff[sel] <= shift_ff;
    end
  end
  assign low_band_ref_divider_latch = lat_ff[SEL_LOW_REF];
  assign low_band_feedback_divider_latch = lat_ff[SEL_LOW_FB];
  assign high_band_ref_divider_latch = lat_ff[SEL_HIGH_REF];
  assign high_band_feedback_divider_latch = lat_ff[SEL_HIGH_FB];
  logic [1:0] lock, rdo, fdo, spd, up, dn;
  loop_section low_loop (
    .aclk(aclk), .aresetn(aresetn), .ref_edge(ref_edge), .vco_edge(lo_edge),
    .ref_latch(lat_ff[SEL_LOW_REF]), .fb_latch(lat_ff[SEL_LOW_FB]),
    .detector_up(up[0]), .detector_down(dn[0]), .lock_detect(lock[0]),
    .ref_div_out(rdo[0]), .fb_div_out(fdo[0]), .speedup_output(spd[0]),
    .pump_tristate(pump_tristate[0]), .pump_current(pump_current[2:0])
  );
  loop_section high_loop (
    .aclk(aclk), .aresetn(aresetn), .ref_edge(ref_edge), .vco_edge(hi_edge),
    .ref_latch(lat_ff[SEL_HIGH_REF]), .fb_latch(lat_ff[SEL_HIGH_FB]),
    .detector_up(up[1]), .detector_down(dn[1]), .lock_detect(lock[1]),
    .ref_div_out(rdo[1]), .fb_div_out(fdo[1]), .speedup_output(spd[1]),
    .pump_tristate(pump_tristate[1]), .pump_current(pump_current[5:3])
  );
  assign detector_up = up;
  assign detector_down = dn;
  assign speedup_output = spd[0] || spd[1];
  wire [3:0] mux_sel = {lat_ff[SEL_HIGH_REF][REF_MUX_HI:REF_MUX_LO], lat_ff[SEL_LOW_REF][REF_MUX_HI:REF_MUX_LO]};
  wire anl_lo = !(up[0] || dn[0]);
  wire anl_hi = !(up[1] || dn[1]);
  logic mux_val, mux_od;
  always_comb begin
    mux_val = 1'b0;
    mux_od = 1'b0;
    unique case (mux_sel)
      4'h0: mux_val = 1'b0;
      4'h1: mux_val = lock[0];
      4'h2: mux_val = fdo[0];
      4'h3: begin mux_val = anl_lo; mux_od = 1'b1; end
      4'h4: mux_val = rdo[0];
      4'h5: mux_val = lock[1];
      4'h6: mux_val = fdo[1];
      4'h7: begin mux_val = anl_hi; mux_od = 1'b1; end
      4'h8: mux_val = lock[0] && lock[1];
      4'h9: begin mux_val = anl_lo && anl_hi; mux_od = 1'b1; end
      4'hA: mux_val = rdo[1];
      4'hB: mux_val = 1'b1;
      default: mux_val = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_ff <= 1'b0;
      mux_oe_ff <= 1'b1;
    end else begin
      mux_ff <= mux_val;
      mux_oe_ff <= mux_od ? !mux_val : 1'b1;
    end
  end
  assign test_mux_output = mux_ff;
  assign test_mux_output_oe = mux_oe_ff;
endmodule

/* File: synth_link_checker.sv */
`timescale 1ns/1ns
module synth_link_checker
  import synth_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_clock,
  input wire logic load_strobe,
  input wire logic speedup_output,
  input wire logic [WORD_W-1:0] low_band_ref_divider_latch,
  input wire logic [WORD_W-1:0] low_band_feedback_divider_latch,
  input wire logic [WORD_W-1:0] high_band_ref_divider_latch,
  input wire logic [WORD_W-1:0] high_band_feedback_divider_latch
);
  logic [5:0] rise_cnt_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Rises since the last load, so a short word is caught
  always_ff @(posedge aclk) begin
    if (!aresetn || load_strobe) begin
      rise_cnt_ff <= 6'h00;
    end else if ($rose(serial_clock)) begin
      rise_cnt_ff <= rise_cnt_ff + 6'h01;
    end
  end
  property p_latch_cause;
    ($changed(low_band_ref_divider_latch) || $changed(low_band_feedback_divider_latch) ||
     $changed(high_band_ref_divider_latch) || $changed(high_band_feedback_divider_latch)) |->
    ($past(load_strobe, 2) || $past(load_strobe, 3) || $past(load_strobe, 4));
  endproperty
  a_latch_cause: assert property (p_latch_cause) else $error("latch changed without load");
  property p_one_latch;
    $onehot0({$changed(low_band_ref_divider_latch), $changed(low_band_feedback_divider_latch),
              $changed(high_band_ref_divider_latch), $changed(high_band_feedback_divider_latch)});
  endproperty
  a_one_latch: assert property (p_one_latch) else $error("several latches changed");
  property p_sel_lr;
    $changed(low_band_ref_divider_latch) |-> low_band_ref_divider_latch[1:0] == SEL_LOW_REF;
  endproperty
  a_sel_lr: assert property (p_sel_lr) else $error("low ref latch wrong select");
  property p_sel_lf;
    $changed(low_band_feedback_divider_latch) |-> low_band_feedback_divider_latch[1:0] == SEL_LOW_FB;
  endproperty
  a_sel_lf: assert property (p_sel_lf) else $error("low fb latch wrong select");
  property p_sel_hr;
    $changed(high_band_ref_divider_latch) |-> high_band_ref_divider_latch[1:0] == SEL_HIGH_REF;
  endproperty
  a_sel_hr: assert property (p_sel_hr) else $error("high ref latch wrong select");
  property p_sel_hf;
    $changed(high_band_feedback_divider_latch) |-> high_band_feedback_divider_latch[1:0] == SEL_HIGH_FB;
  endproperty
  a_sel_hf: assert property (p_sel_hf) else $error("high fb latch wrong select");
  property p_load_width;
    $rose(load_strobe) |-> load_strobe [*5] ##1 !load_strobe;
  endproperty
  a_load_width: assert property (p_load_width) else $error("load pulse width wrong");
  property p_clk_high;
    $rose(serial_clock) |-> serial_clock [*5] ##1 !serial_clock;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("serial clock high phase wrong");
  property p_no_overlap;
    !(serial_clock && load_strobe);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("clock high during load");
  property p_bit_count;
    $rose(load_strobe) |-> rise_cnt_ff == 6'h18;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("word not 24 bits");
  property p_speedup;
    speedup_output == (low_band_feedback_divider_latch[FB_GAIN] | high_band_feedback_divider_latch[FB_GAIN]);
  endproperty
  a_speedup: assert property (p_speedup) else $error("speedup output wrong");
endmodule

/* File: dual_pll_divider_serial_load_tb.sv */
`timescale 1ns/1ns
module dual_pll_divider_serial_load_tb
  import synth_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, mux_out, mux_oe, speedup;
  wire [1:0] bresp, rresp, pt, dup, ddn;
  wire [31:0] rdata;
  wire [5:0] pc;
  wire [23:0] lr, lf, hr, hf;
  logic [23:0] exp_l [4];
  logic [1:0] resp;
  logic [31:0] rd;
  int n;
  // Pin periods in clock cycles, well over the sync limit
  localparam int VCO_LO_CYC = 4;
  localparam int REF_CYC = 16;
  logic ref_in = 1'b0, lo_vco = 1'b0, hi_vco = 1'b0;
  int bad_count = 0, check_count = 0, cycles = 0;
  serial_link_if link();
  always #5 aclk = ~aclk;
  synth_host synth_host_i (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  synth_device synth_device_i (.aclk(aclk), .aresetn(aresetn), .link(link), .reference_input(ref_in),
    .low_band_vco_input(lo_vco), .high_band_vco_input(hi_vco), .test_mux_output(mux_out),
    .test_mux_output_oe(mux_oe), .speedup_output(speedup), .detector_up(dup), .detector_down(ddn),
    .pump_tristate(pt), .pump_current(pc), .low_band_ref_divider_latch(lr),
    .low_band_feedback_divider_latch(lf), .high_band_ref_divider_latch(hr),
    .high_band_feedback_divider_latch(hf));
  synth_link_checker synth_link_checker_i (.aclk(aclk), .aresetn(aresetn), .serial_clock(link.serial_clock),
    .load_strobe(link.load_strobe), .speedup_output(speedup), .low_band_ref_divider_latch(lr),
    .low_band_feedback_divider_latch(lf), .high_band_ref_divider_latch(hr),
    .high_band_feedback_divider_latch(hf));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Long enough for about seventy-five words over the slow link
  always @(posedge aclk) begin
    cycles++;
    ref_in <= cycles[3];
    lo_vco <= cycles[1];
    hi_vco <= cycles[2];
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    @(posedge aclk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Latch output trails the load pulse by a few cycles
  task automatic wait_idle();
    do axi_read(ADDR_STAT, rd, resp); while (rd[0] === 1'b1);
    repeat (5) @(posedge aclk);
  endtask
  task automatic send(input logic [23:0] w);
    axi_write(ADDR_DATA, {8'h00, w}, resp);
    check(32'(resp), 32'(RESP_OKAY));
    axi_write(ADDR_CTRL, 32'h0000_0001, resp);
    check(32'(resp), 32'(RESP_OKAY));
    wait_idle();
    exp_l[w[1:0]] = w;
  endtask
  task automatic check_latches();
    check(32'(lr), 32'(exp_l[0]));
    check(32'(lf), 32'(exp_l[1]));
    check(32'(hr), 32'(exp_l[2]));
    check(32'(hf), 32'(exp_l[3]));
  endtask
  // Period of the muxed divider pulse; skips the first, partial one and the next full one
  task automatic gap(output int g);
    repeat (2) do @(posedge aclk); while (mux_out !== 1'b1);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (mux_out !== 1'b1);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) exp_l[i] = 24'h000000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check_latches();
    axi_read(ADDR_STAT, rd, resp);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    send({3'h5, 2'h0, 1'b0, 1'b1, 15'h7FFF, SEL_LOW_REF});
    check_latches();
    send({1'b0, 1'b0, 2'h0, B_MIN, 6'h3F, SEL_LOW_FB});
    check_latches();
    send({3'h2, 2'h0, 1'b1, 1'b0, 15'h0001, SEL_HIGH_REF});
    check_latches();
    send({1'b0, 1'b0, 2'h3, 12'hFFF, 6'h00, SEL_HIGH_FB});
    check_latches();
    check(32'(pt), 32'h2);
    check(32'(mux_out), 32'h0);
    $display("test latch select done");
    for (int p = 0; p < 4; p++) begin
      send({1'b1, 1'b0, 2'(p), 12'h123, 6'h15, SEL_LOW_FB});
      check(32'(lf[FB_PRE_HI:FB_PRE_LO]), 32'(p));
      check(32'(speedup), 32'h1);
      check(32'(pc[2:0]), 32'h7);
    end
    send({1'b0, 1'b0, 2'h1, 12'h123, 6'h15, SEL_LOW_FB});
    check(32'(speedup), 32'h0);
    send({3'h1, 2'h3, 1'b0, 1'b1, 15'h0010, SEL_LOW_REF});
    send({3'h1, 2'h2, 1'b0, 1'b1, 15'h0010, SEL_HIGH_REF});
    check(32'(mux_out), 32'h1);
    check(32'(mux_oe), 32'h1);
    check_latches();
    $display("test speedup and mux done");
    axi_read(4'hC, rd, resp);
    check(rd, 32'h0000_0000);
    check(32'(resp), 32'(RESP_SLVERR));
    axi_write(4'hC, 32'h0000_0001, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    axi_write(ADDR_DATA, 32'h00A5_5A02, resp);
    axi_write(ADDR_CTRL, 32'h0000_0001, resp);
    check(32'(resp), 32'(RESP_OKAY));
    axi_write(ADDR_CTRL, 32'h0000_0001, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    wait_idle();
    exp_l[2] = 24'hA55A02;
    check_latches();
    check(32'(pc[5:3]), 32'h5);
    $display("test refusals done");
    send({1'b0, 1'b1, 2'h0, 12'h010, 6'h01, SEL_LOW_FB});
    send({3'h7, 2'h0, 1'b0, 1'b0, 15'h3FFF, SEL_LOW_REF});
    check_latches();
    check(32'(dup), 32'h0);
    check(32'(ddn), 32'h0);
    $display("test power-down done");
    send({1'b0, 1'b0, 2'h0, B_MIN, 6'h01, SEL_LOW_FB});
    send({3'h1, 2'h2, 1'b0, 1'b1, 15'h0003, SEL_LOW_REF});
    gap(n);
    check(32'(n), 32'((8 * 3 + 1) * VCO_LO_CYC));
    send({3'h1, 2'h1, 1'b0, 1'b1, 15'h0001, SEL_HIGH_REF});
    send({3'h1, 2'h0, 1'b0, 1'b1, 15'h0003, SEL_LOW_REF});
    gap(n);
    check(32'(n), 32'(3 * REF_CYC));
    check_latches();
    $display("test dividers done");
    conclude();
  end
endmodule
